// *** hw/pif_pkg.sv ***
package pif_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [4:0]  IDX_EVENT_FLAGS  = 5'h1D;
    localparam logic [4:0]  IDX_EVENT_ENABLE = 5'h1E;
    localparam logic [4:0]  IDX_IRQ_STATUS   = 5'h10;
    localparam logic [4:0]  IDX_IRQ_CLEAR    = 5'h11;
    localparam logic [4:0]  IDX_IRQ_ENABLE   = 5'h12;
    localparam logic [4:0]  IDX_XOVER_STAT   = 5'h13;
    localparam int          REG_W            = 16;
    // flag and enable field positions
    localparam int          BIT_PAGE_RX      = 1;
    localparam int          BIT_PD_FAULT     = 2;
    localparam int          BIT_PARTNER_ACK  = 3;
    localparam int          BIT_LINK_LOST    = 4;
    localparam int          BIT_REMOTE_FAULT = 5;
    localparam int          BIT_AUTONEG_DONE = 6;
    localparam int          BIT_ENERGY       = 7;
    localparam logic [15:0] EVENT_FIELD_MASK = 16'h00FE;
    localparam logic [15:0] FLAGS_RESET      = 16'h0000;
    localparam logic [15:0] ENABLE_RESET     = 16'h0000;
    // link-lost level starts high so leaving reset is not taken as a link loss
    localparam logic [15:0] LEVEL_RESET      = 16'h0010;
    // system interrupt status bits
    localparam int          SYS_BIT_FLAGS    = 0;
    localparam int          SYS_BIT_BADADDR  = 1;
    localparam logic [1:0]  SYS_RESET        = 2'h0;
    // AXI responses
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;
    // crossover modes
    typedef enum logic [2:0]
    {
        PIF_XOVER_STRAIGHT = 3'h1,
        PIF_XOVER_CROSS    = 3'h2,
        PIF_XOVER_AUTO     = 3'h4
    } pif_xover_t;
endpackage

// *** hw/pif_xover_decode.sv ***
`timescale 1ns/1ps
// crossover strap decode; straps captured after reset release
module pif_xover_decode
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    // straps
    input  wire logic              auto_strap,
    input  wire logic              manual_strap,
    // decoded mode
    output pif_pkg::pif_xover_t    mode
);
    logic captured_r;

    // async reset loads constants only; straps taken once, at first enabled edge;
    // mode is kept in a flop so the output never glitches; auto strap wins
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            captured_r <= 1'b0;
            mode       <= pif_pkg::PIF_XOVER_STRAIGHT;
        end
        else if (ce && !captured_r)
        begin
            captured_r <= 1'b1;
            if (auto_strap)
                mode <= pif_pkg::PIF_XOVER_AUTO;
            else if (manual_strap)
                mode <= pif_pkg::PIF_XOVER_CROSS;
            else
                mode <= pif_pkg::PIF_XOVER_STRAIGHT;
        end
    end
endmodule // pif_xover_decode

// *** hw/pif_event_latch.sv ***
`timescale 1ns/1ps
// sticky flag bank: set on enabled event, clear on read; set beats clear
module pif_event_latch #(
    parameter int W = 16
)
(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          ce,
    // control
    input  wire logic [W-1:0]  set_in,
    input  wire logic [W-1:0]  gate,
    input  wire logic          clr,
    // state
    output logic      [W-1:0]  flags_r
);
    logic [W-1:0] flags_nxt;

    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            // an event in the clearing cycle survives the clear
            assign flags_nxt[g] = (set_in[g] & gate[g]) | (flags_r[g] & ~clr);
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            flags_r <= '0;
        else if (ce)
            flags_r <= flags_nxt;
    end
endmodule // pif_event_latch

// *** hw/pif_phy_irq.sv ***
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
// Summary of operation
// - Auto strap high selects auto crossover, else the manual strap picks straight or crossed.
// - The 16-bit flag register sits at index 29 and ignores software writes.
// - A flag latches high on its event only when enabled, and all flags reset to zero.
// - A read of the flag register clears every latched flag.
// - Bit 7 sets when line energy becomes present.
// - Bit 6 sets when auto-negotiation completes.
// - Bit 5 sets when a remote fault is detected.
// - Bit 4 sets when the link goes down.
// - Bit 3 sets on a link-partner acknowledge.
// - Bit 2 sets on a parallel detection fault.
// - Bit 1 sets when a page is received.
// - The 16-bit enable register at index 30 is read/write, bits 7..1 matching the flags.
// - Enable zero blocks a source, one passes it, and all enables reset to zero.
module pif_phy_irq
(
    // clock, reset, enable
    input  wire logic              CLK_SYS,
    input  wire logic              RESET_N,
    input  wire logic              CE,
    // phy status inputs
    input  wire logic              LINE_ENERGY_PRESENT,
    input  wire logic              AUTONEG_DONE,
    input  wire logic              REMOTE_FAULT,
    input  wire logic              LINK_UP,
    input  wire logic              PARTNER_ACK,
    input  wire logic              PARALLEL_DETECT_FAULT,
    input  wire logic              PAGE_RECEIVED,
    // crossover straps and decoded mode
    input  wire logic              AUTO_XOVER_STRAP,
    input  wire logic              MANUAL_XOVER_STRAP,
    output pif_pkg::pif_xover_t    XOVER_MODE,
    // interrupts
    output logic                   PORT_IRQ,
    output logic                   SYS_IRQ,
    // axi4-lite write address
    input  wire logic [7:0]        S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output logic                   S_AXI_AWREADY,
    // axi4-lite write data
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output logic                   S_AXI_WREADY,
    // axi4-lite write response
    output logic [1:0]             S_AXI_BRESP,
    output logic                   S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    // axi4-lite read address
    input  wire logic [7:0]        S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output logic                   S_AXI_ARREADY,
    // axi4-lite read data
    output logic [31:0]            S_AXI_RDATA,
    output logic [1:0]             S_AXI_RRESP,
    output logic                   S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY
);
    logic [15:0] enable_r;
    logic [15:0] flags_r;
    logic [15:0] events;
    logic [15:0] live_events;
    logic [15:0] prev_lvl_r;
    logic [15:0] lvl;
    logic [1:0]  sys_stat_r;
    logic [1:0]  sys_en_r;
    logic        aw_held_r;
    logic        w_held_r;
    logic [7:0]  aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        wr_go;
    logic        rd_go;
    logic        flags_read;
    logic        bad_wr;
    logic        bad_rd;
    logic [1:0]  sys_clr;

    // word index from a byte address; misaligned or out of range gives 0x1F
    function automatic logic [4:0] word_idx(input logic [7:0] a);
        word_idx = (a[1:0] == 2'h0) ? a[6:2] : 5'h1F;
        if (a[7])
            word_idx = 5'h1F;
    endfunction

    function automatic logic is_mapped(input logic [4:0] i);
        is_mapped = (i == pif_pkg::IDX_EVENT_FLAGS) || (i == pif_pkg::IDX_EVENT_ENABLE) ||
                    (i == pif_pkg::IDX_IRQ_STATUS) || (i == pif_pkg::IDX_IRQ_CLEAR) ||
                    (i == pif_pkg::IDX_IRQ_ENABLE) || (i == pif_pkg::IDX_XOVER_STAT);
    endfunction

    // strap decode
    pif_xover_decode u_xover
    (
        .clk          (CLK_SYS),
        .rst_n        (RESET_N),
        .ce           (CE),
        .auto_strap   (AUTO_XOVER_STRAP),
        .manual_strap (MANUAL_XOVER_STRAP),
        .mode         (XOVER_MODE)
    );

    // status levels at their flag positions; link lost uses inverted link-up
    always_comb
    begin
        lvl                            = '0;
        lvl[pif_pkg::BIT_ENERGY]       = LINE_ENERGY_PRESENT;
        lvl[pif_pkg::BIT_AUTONEG_DONE] = AUTONEG_DONE;
        lvl[pif_pkg::BIT_REMOTE_FAULT] = REMOTE_FAULT;
        lvl[pif_pkg::BIT_LINK_LOST]    = ~LINK_UP;
        lvl[pif_pkg::BIT_PARTNER_ACK]  = PARTNER_ACK;
        lvl[pif_pkg::BIT_PD_FAULT]     = PARALLEL_DETECT_FAULT;
        lvl[pif_pkg::BIT_PAGE_RX]      = PAGE_RECEIVED;
    end

    // previous levels; link starts "down" so reset does not fake a link loss
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
            prev_lvl_r <= pif_pkg::LEVEL_RESET;
        else if (CE)
            prev_lvl_r <= lvl;
    end

    // rising edges only: a stuck status must not refire after each read
    assign events = lvl & ~prev_lvl_r & pif_pkg::EVENT_FIELD_MASK;

    // read of the flag register clears the bank
    assign flags_read = rd_go && (word_idx(S_AXI_ARADDR) == pif_pkg::IDX_EVENT_FLAGS);

    pif_event_latch #(.W(16)) u_flags
    (
        .clk     (CLK_SYS),
        .rst_n   (RESET_N),
        .ce      (CE),
        .set_in  (events),
        .gate    (enable_r),
        .clr     (flags_read),
        .flags_r (flags_r)
    );

    assign PORT_IRQ = |flags_r;

    // enabled events of this cycle, watched by the checks below
    assign live_events = events & enable_r;

    // write channel capture: address and data accepted in either order;
    // readies drop with CE so a frozen slave never fakes a handshake
    assign S_AXI_AWREADY = CE && !aw_held_r && !S_AXI_BVALID;
    assign S_AXI_WREADY  = CE && !w_held_r && !S_AXI_BVALID;
    assign wr_go         = aw_held_r && w_held_r && !S_AXI_BVALID;

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
        end
        else if (CE)
        begin
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_held_r <= 1'b1;
                aw_addr_r <= S_AXI_AWADDR;
            end
            else if (wr_go)
                aw_held_r <= 1'b0;
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_held_r <= 1'b1;
                w_data_r <= S_AXI_WDATA;
                w_strb_r <= S_AXI_WSTRB;
            end
            else if (wr_go)
                w_held_r <= 1'b0;
        end
    end

    assign bad_wr = wr_go && !is_mapped(word_idx(aw_addr_r));

    // write response one cycle after both halves are held
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= pif_pkg::RESP_OKAY;
        end
        else if (CE)
        begin
            if (wr_go)
            begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= bad_wr ? pif_pkg::RESP_SLVERR : pif_pkg::RESP_OKAY;
            end
            else if (S_AXI_BREADY)
                S_AXI_BVALID <= 1'b0;
        end
    end

    // enable registers; flag register has no write path at all
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            enable_r <= pif_pkg::ENABLE_RESET;
            sys_en_r <= pif_pkg::SYS_RESET;
        end
        else if (CE && wr_go)
        begin
            if (word_idx(aw_addr_r) == pif_pkg::IDX_EVENT_ENABLE)
            begin
                if (w_strb_r[0])
                    enable_r[7:0] <= w_data_r[7:0] & pif_pkg::EVENT_FIELD_MASK[7:0];
            end
            if (word_idx(aw_addr_r) == pif_pkg::IDX_IRQ_ENABLE && w_strb_r[0])
                sys_en_r <= w_data_r[1:0];
        end
    end

    // write-one-to-clear for system status
    assign sys_clr = (wr_go && word_idx(aw_addr_r) == pif_pkg::IDX_IRQ_CLEAR && w_strb_r[0]) ? w_data_r[1:0] : 2'h0;

    // system status: enabled event seen, and bad address; set beats clear
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
            sys_stat_r <= pif_pkg::SYS_RESET;
        else if (CE)
        begin
            sys_stat_r[pif_pkg::SYS_BIT_FLAGS]   <= (|(events & enable_r)) |
                                                    (sys_stat_r[pif_pkg::SYS_BIT_FLAGS] & ~sys_clr[0]);
            sys_stat_r[pif_pkg::SYS_BIT_BADADDR] <= bad_wr | bad_rd |
                                                    (sys_stat_r[pif_pkg::SYS_BIT_BADADDR] & ~sys_clr[1]);
        end
    end

    assign SYS_IRQ = |(sys_stat_r & sys_en_r);

    // read channel: one outstanding read
    assign S_AXI_ARREADY = CE && !S_AXI_RVALID;
    assign rd_go         = CE && S_AXI_ARVALID && S_AXI_ARREADY;
    assign bad_rd        = rd_go && !is_mapped(word_idx(S_AXI_ARADDR));

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h0000_0000;
            S_AXI_RRESP  <= pif_pkg::RESP_OKAY;
        end
        else if (CE)
        begin
            if (rd_go)
            begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP  <= bad_rd ? pif_pkg::RESP_SLVERR : pif_pkg::RESP_OKAY;
                case (word_idx(S_AXI_ARADDR))
                    pif_pkg::IDX_EVENT_FLAGS:  S_AXI_RDATA <= {16'h0000, flags_r & pif_pkg::EVENT_FIELD_MASK};
                    pif_pkg::IDX_EVENT_ENABLE: S_AXI_RDATA <= {16'h0000, enable_r & pif_pkg::EVENT_FIELD_MASK};
                    pif_pkg::IDX_IRQ_STATUS:   S_AXI_RDATA <= {30'h0000_0000, sys_stat_r};
                    pif_pkg::IDX_IRQ_ENABLE:   S_AXI_RDATA <= {30'h0000_0000, sys_en_r};
                    pif_pkg::IDX_XOVER_STAT:   S_AXI_RDATA <= {29'h0000_0000, XOVER_MODE};
                    default:                   S_AXI_RDATA <= 32'h0000_0000;
                endcase
            end
            else if (S_AXI_RREADY)
                S_AXI_RVALID <= 1'b0;
        end
    end

    // assertions
    property p_mask_blocks;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (CE && !enable_r[pif_pkg::BIT_ENERGY] && !flags_r[pif_pkg::BIT_ENERGY]) |=> !flags_r[pif_pkg::BIT_ENERGY];
    endproperty
    a_mask_blocks: assert property (p_mask_blocks) else $error("masked energy flag set");

    property p_latch_set;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (CE && events[pif_pkg::BIT_AUTONEG_DONE] && enable_r[pif_pkg::BIT_AUTONEG_DONE])
            |=> flags_r[pif_pkg::BIT_AUTONEG_DONE];
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("enabled event not latched");

    property p_read_clears;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (flags_read && !(|(events & enable_r))) |=> (flags_r == 16'h0000);
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read did not clear flags");

    property p_flags_hold;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (!flags_read && !(|(events & enable_r))) |=> (flags_r == $past(flags_r));
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("flags changed without cause");

    property p_reserved_zero;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        ((flags_r & ~pif_pkg::EVENT_FIELD_MASK) == 16'h0000) && ((enable_r & ~pif_pkg::EVENT_FIELD_MASK) == 16'h0000);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_port_irq;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        $rose(PORT_IRQ) |-> ($past(live_events) != 16'h0000);
    endproperty
    a_port_irq: assert property (p_port_irq) else $error("port irq rose without an enabled event");

    // a fall across reset release is not seen: the level history restarts there
    property p_link_lost;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (CE && $fell(LINK_UP) && enable_r[pif_pkg::BIT_LINK_LOST] && $past(CE) && $past(RESET_N))
            |=> flags_r[pif_pkg::BIT_LINK_LOST];
    endproperty
    a_link_lost: assert property (p_link_lost) else $error("link loss not flagged");

    property p_enable_write;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (CE && wr_go && word_idx(aw_addr_r) == pif_pkg::IDX_EVENT_ENABLE && w_strb_r[0])
            |=> (enable_r[7:0] == ($past(w_data_r[7:0]) & 8'hFE));
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable write lost");

    property p_xover;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        ($rose(u_xover.captured_r) && $past(AUTO_XOVER_STRAP)) |-> (XOVER_MODE == pif_pkg::PIF_XOVER_AUTO);
    endproperty
    a_xover: assert property (p_xover) else $error("auto strap ignored");

    property p_ce_freeze;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        !CE |=> (flags_r == $past(flags_r));
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("flags moved while clock enable low");

    c_flag_read: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) PORT_IRQ ##[1:20] flags_read);
    c_set_vs_clr: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) flags_read && |(events & enable_r));
    c_bad_addr: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) bad_rd || bad_wr);
    c_frozen: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) !CE && (events != 16'h0000));
endmodule // pif_phy_irq

// *** verification/pif_phy_irq_bench.sv ***
`timescale 1ns/1ps
module pif_phy_irq_bench;
    typedef struct packed
    {
        logic [31:0] en;
        logic [7:0]  ev;
        logic [15:0] exp_flags;
    } pif_row_t;
    localparam logic [7:0] A_FLAGS  = {1'b0, pif_pkg::IDX_EVENT_FLAGS, 2'b00};
    localparam logic [7:0] A_ENABLE = {1'b0, pif_pkg::IDX_EVENT_ENABLE, 2'b00};
    localparam logic [7:0] A_STAT   = {1'b0, pif_pkg::IDX_IRQ_STATUS, 2'b00};
    localparam logic [7:0] A_CLR    = {1'b0, pif_pkg::IDX_IRQ_CLEAR, 2'b00};
    localparam logic [7:0] A_SYSEN  = {1'b0, pif_pkg::IDX_IRQ_ENABLE, 2'b00};
    localparam logic [7:0] A_XSTAT  = {1'b0, pif_pkg::IDX_XOVER_STAT, 2'b00};
    // bench state; ev bit n stands for the event of flag n, bit 4 is the inverted link
    logic                clk_sys, reset_n, ce, auto_strap, manual_strap, port_irq, sys_irq;
    logic [7:0]          ev, awaddr, araddr;
    logic                link_up, awvalid, awready, wvalid, wready, bvalid, bready;
    logic                arvalid, arready, rvalid, rready;
    logic [31:0]         wdata, rdata, rd;
    logic [3:0]          wstrb;
    logic [1:0]          bresp, rresp, resp;
    pif_pkg::pif_xover_t xover_mode, xexp;
    pif_row_t            rows [12];
    int                  failures, n_compared;
    assign link_up = ~ev[4];
    pif_phy_irq pif_phy_irq_inst
    (
        .CLK_SYS(clk_sys), .RESET_N(reset_n), .CE(ce),
        .LINE_ENERGY_PRESENT(ev[7]), .AUTONEG_DONE(ev[6]), .REMOTE_FAULT(ev[5]), .LINK_UP(link_up),
        .PARTNER_ACK(ev[3]), .PARALLEL_DETECT_FAULT(ev[2]), .PAGE_RECEIVED(ev[1]),
        .AUTO_XOVER_STRAP(auto_strap), .MANUAL_XOVER_STRAP(manual_strap), .XOVER_MODE(xover_mode),
        .PORT_IRQ(port_irq), .SYS_IRQ(sys_irq),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
    );
    // free-running system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expd);
        n_compared++;
        if (seen !== expd)
        begin
            failures++;
            $display("unexpected %0s: expected %h, seen %h", what, expd, seen);
        end
    endtask
    // write with address and data offered together; bready held until the response
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk_sys);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= 4'hF;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 40);
        r = bresp;
        bready <= 1'b0;
        if (n >= 40)
            failures++;
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk_sys);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
            if (arvalid && arready)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 40);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n >= 40)
            failures++;
    endtask
    // one-cycle event pulse, then let the flags settle
    task automatic pulse(input logic [7:0] e);
        @(posedge clk_sys);
        ev <= e;
        @(posedge clk_sys);
        ev <= 8'h00;
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // watchdog: the whole run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        failures++;
        end_of_test();
    end
    // main sequence
    initial
    begin
        failures = 0; n_compared = 0; reset_n = 1'b0; ce = 1'b1; ev = 8'h00;
        auto_strap = 1'b0; manual_strap = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
        wstrb = 4'h0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        rows = '{'{32'h00FE, 8'h80, 16'h0080}, '{32'h00FE, 8'h40, 16'h0040}, '{32'h00FE, 8'h20, 16'h0020},
                 '{32'h00FE, 8'h10, 16'h0010}, '{32'h00FE, 8'h08, 16'h0008}, '{32'h00FE, 8'h04, 16'h0004},
                 '{32'h00FE, 8'h02, 16'h0002}, '{32'h0000, 8'hFE, 16'h0000}, '{32'h00AA, 8'hFE, 16'h00AA},
                 '{32'h0054, 8'hFE, 16'h0054}, '{32'h0080, 8'h7E, 16'h0000}, '{32'hFFFFFFFF, 8'hFF, 16'h00FE}};
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        // table of enable settings against event patterns
        for (int i = 0; i < 12; i++)
        begin
            axi_write(A_ENABLE, rows[i].en, resp);
            check("enable write resp", {30'h0, resp}, {30'h0, pif_pkg::RESP_OKAY});
            axi_read(A_ENABLE, rd, resp);
            check("enable", rd, rows[i].en & 32'h0000_00FE);
            pulse(rows[i].ev);
            check("port irq set", {31'h0, port_irq}, {31'h0, |rows[i].exp_flags});
            axi_read(A_FLAGS, rd, resp);
            check("flags", rd, {16'h0, rows[i].exp_flags});
            axi_read(A_FLAGS, rd, resp);
            check("flags after read", rd, 32'h0);
            check("port irq clear", {31'h0, port_irq}, 32'h0);
        end
        $display("test event table finished");
        // clock enable low freezes the block: events then leave no trace
        ce <= 1'b0;
        pulse(8'hFE);
        ce <= 1'b1;
        check("frozen port irq", {31'h0, port_irq}, 32'h0);
        axi_read(A_FLAGS, rd, resp);
        check("frozen flags", rd, 32'h0);
        $display("test clock enable finished");
        // software writes leave the flags alone; a held level is not a new event
        pulse(8'h00);
        @(posedge clk_sys);
        ev <= 8'h80;
        repeat (2) @(posedge clk_sys);
        axi_write(A_FLAGS, 32'h0000_0000, resp);
        axi_write(A_FLAGS, 32'h0000_FFFF, resp);
        axi_read(A_FLAGS, rd, resp);
        check("flags after write", rd, 32'h0000_0080);
        axi_read(A_FLAGS, rd, resp);
        check("flags level held", rd, 32'h0);
        @(posedge clk_sys);
        ev <= 8'h00;
        $display("test read-only flags finished");
        // system interrupt: raise, mask, clear; bad addresses answer with an error
        axi_write(A_CLR, 32'h0000_0003, resp);
        axi_read(A_STAT, rd, resp);
        check("sys status cleared", rd, 32'h0);
        axi_read(8'h00, rd, resp);
        check("unmapped resp", {30'h0, resp}, {30'h0, pif_pkg::RESP_SLVERR});
        check("unmapped data", rd, 32'h0);
        axi_write(8'h75, 32'h0000_00FF, resp);
        check("misaligned resp", {30'h0, resp}, {30'h0, pif_pkg::RESP_SLVERR});
        axi_read(A_STAT, rd, resp);
        check("sys status bad addr", rd, 32'h0000_0002);
        repeat (2) @(posedge clk_sys);
        check("sys irq masked", {31'h0, sys_irq}, 32'h0);
        axi_write(A_SYSEN, 32'h0000_0003, resp);
        repeat (2) @(posedge clk_sys);
        check("sys irq raised", {31'h0, sys_irq}, 32'h1);
        axi_write(A_CLR, 32'h0000_0002, resp);
        repeat (2) @(posedge clk_sys);
        check("sys irq cleared", {31'h0, sys_irq}, 32'h0);
        pulse(8'h20);
        check("sys irq on flag", {31'h0, sys_irq}, 32'h1);
        check("port irq on flag", {31'h0, port_irq}, 32'h1);
        $display("test system interrupt finished");
        // reset in mid-run with each strap setting
        for (int j = 0; j < 4; j++)
        begin
            @(posedge clk_sys);
            auto_strap   <= j[1];
            manual_strap <= j[0];
            reset_n      <= 1'b0;
            repeat (2) @(posedge clk_sys);
            check("port irq in reset", {31'h0, port_irq}, 32'h0);
            check("xover in reset", {29'h0, xover_mode}, {29'h0, pif_pkg::PIF_XOVER_STRAIGHT});
            reset_n <= 1'b1;
            repeat (3) @(posedge clk_sys);
            xexp = j[1] ? pif_pkg::PIF_XOVER_AUTO : (j[0] ? pif_pkg::PIF_XOVER_CROSS : pif_pkg::PIF_XOVER_STRAIGHT);
            check("xover mode", {29'h0, xover_mode}, {29'h0, xexp});
            axi_read(A_XSTAT, rd, resp);
            check("xover status", rd, {29'h0, xexp});
            axi_read(A_FLAGS, rd, resp);
            check("flags reset", rd, {16'h0, pif_pkg::FLAGS_RESET});
            axi_read(A_ENABLE, rd, resp);
            check("enable reset", rd, {16'h0, pif_pkg::ENABLE_RESET});
            pulse(8'hFE);
            check("blocked after reset", {31'h0, port_irq}, 32'h0);
        end
        $display("test reset and straps finished");
        end_of_test();
    end
endmodule // pif_phy_irq_bench
